// File: design/fdi_drive.sv
// Drive-side logic of an 8-inch single-density flexible disk interface.
// Assumes all interface lines are active-low wires from another clock
// domain, and that mechanism sensors arrive as active-high levels.
`timescale 1ns/1ps
`default_nettype none
`include "fdi_params.svh"

module fdi_drive #(
    parameter int INDEX_CYC = `FDI_INDEX_CYC
) (
    input  wire logic       REF_CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic       STEP_N_I,
    input  wire logic       DIR_IN_N_I,
    input  wire logic       SELECT_N_I,
    input  wire logic       WR_EN_N_I,
    input  wire logic       WF_CLEAR_N_I,
    input  wire logic       WR_DATA_N_I,
    input  wire logic       LOW_CUR_N_I,
    input  wire logic       POWER_OK_I,
    input  wire logic       DOOR_CLOSED_I,
    input  wire logic       SPEED_OK_I,
    input  wire logic       PROTECT_HOLE_I,
    input  wire logic       INDEX_HOLE_I,
    input  wire logic       RD_DATA_BIT_I,
    input  wire logic       RD_CLK_BIT_I,
    input  wire logic       HEAD_STRAP_I,
    output logic            INDEX_N_O,
    output logic            TRACK0_N_O,
    output logic            PROTECT_N_O,
    output logic            WR_FAULT_N_O,
    output logic            READY_N_O,
    output logic            RD_DATA_N_O,
    output logic            RD_CLK_N_O,
    output logic            HEAD_LOAD_O,
    output logic            WR_GATE_O,
    output logic            ERASE_O,
    output logic            LOW_CUR_O,
    output logic            WR_BIT_O,
    output logic            STEP_IN_O,
    output logic            STEP_OUT_O,
    output fdi_pkg::fdi_track_t TRACK_O
);

    localparam int PULSE_CYC  = `FDI_PULSE_CYC;
    localparam int NODATA_CYC = `FDI_NODATA_CYC;
    localparam int NODATA_NXT = NODATA_CYC + 1;

    logic [14:0]          sync_d;
    logic [14:0]          sync_q;
    logic                 step_s, dir_s, sel_s, wen_s, wfr_s, wd_s, lowc_s;
    logic                 pwr_s, door_s, spd_s, prot_s, idx_s, rdd_s, rdc_s, strap_s;
    logic [2:0]           prev_q;
    logic                 step_rise, idx_rise, wd_fall;
    logic                 rdd_prev_q, rdc_prev_q;
    fdi_pkg::fdi_track_t  track_q;
    logic [17:0]          idx_cnt_q;
    logic [4:0]           rdd_cnt_q, rdc_cnt_q;
    logic [9:0]           nodata_q;
    logic                 wf_q, wf_set;
    fdi_pkg::fdi_wr_state_t wstate_q;

    assign sync_d = {HEAD_STRAP_I, RD_CLK_BIT_I, RD_DATA_BIT_I, INDEX_HOLE_I, PROTECT_HOLE_I,
                     SPEED_OK_I, DOOR_CLOSED_I, POWER_OK_I, ~LOW_CUR_N_I, ~WR_DATA_N_I,
                     ~WF_CLEAR_N_I, ~WR_EN_N_I, ~SELECT_N_I, ~DIR_IN_N_I, ~STEP_N_I};

    fdi_sync #(.WIDTH(15)) u_sync (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .d_i     (sync_d),
        .q_o     (sync_q)
    );

    assign {strap_s, rdc_s, rdd_s, idx_s, prot_s, spd_s, door_s, pwr_s,
            lowc_s, wd_s, wfr_s, wen_s, sel_s, dir_s, step_s} = sync_q;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            prev_q     <= 3'h0;
            rdd_prev_q <= 1'b0;
            rdc_prev_q <= 1'b0;
        end else begin
            prev_q     <= {step_s, idx_s, wd_s};
            rdd_prev_q <= rdd_s;
            rdc_prev_q <= rdc_s;
        end
    end

    assign step_rise = step_s & ~prev_q[2];
    assign idx_rise  = idx_s & ~prev_q[1];
    assign wd_fall   = ~wd_s & prev_q[0];

    // one track per step
    // Direction is sampled at the step's leading edge; the controller keeps it stable.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            track_q    <= 7'(`FDI_TRACK_RST);
            STEP_IN_O  <= 1'b0;
            STEP_OUT_O <= 1'b0;
        end else begin
            STEP_IN_O  <= 1'b0;
            STEP_OUT_O <= 1'b0;
            if (step_rise) begin
                if (dir_s && track_q != 7'(`FDI_TRACK_LAST)) begin
                    track_q   <= track_q + 7'h01;
                    STEP_IN_O <= 1'b1;
                end else if (!dir_s && track_q != 7'h00) begin
                    track_q    <= track_q - 7'h01;
                    STEP_OUT_O <= 1'b1;
                end
            end
        end
    end

    assign TRACK_O = track_q;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            TRACK0_N_O <= 1'b1;
        end else begin
            TRACK0_N_O <= (track_q != 7'h00);
        end
    end

    // status levels
    // Low current is passed on ungated; the write driver applies it only while writing.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            HEAD_LOAD_O <= 1'b0;
            READY_N_O   <= 1'b1;
            PROTECT_N_O <= 1'b1;
            LOW_CUR_O   <= 1'b0;
        end else begin
            HEAD_LOAD_O <= sel_s & strap_s;
            READY_N_O   <= ~(pwr_s & door_s & spd_s);
            PROTECT_N_O <= ~prot_s;
            LOW_CUR_O   <= lowc_s;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wstate_q <= fdi_pkg::FDI_WS_IDLE;
        end else begin
            unique case (wstate_q)
                fdi_pkg::FDI_WS_IDLE:  if (wen_s) wstate_q <= prot_s ? fdi_pkg::FDI_WS_BLOCK
                                                                     : fdi_pkg::FDI_WS_WRITE;
                fdi_pkg::FDI_WS_WRITE: if (!wen_s) wstate_q <= fdi_pkg::FDI_WS_IDLE;
                                       else if (prot_s) wstate_q <= fdi_pkg::FDI_WS_BLOCK;
                fdi_pkg::FDI_WS_BLOCK: if (!wen_s) wstate_q <= fdi_pkg::FDI_WS_IDLE;
                default:               wstate_q <= fdi_pkg::FDI_WS_IDLE;
            endcase
        end
    end

    assign WR_GATE_O = (wstate_q == fdi_pkg::FDI_WS_WRITE) & ~prot_s;
    assign ERASE_O   = WR_GATE_O;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            WR_BIT_O <= 1'b0;
        end else begin
            WR_BIT_O <= wd_fall & WR_GATE_O;
        end
    end

    // missing data watchdog
    // Two nominal bit cells without a pulse means the stream has stopped.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            nodata_q <= 10'h000;
        end else if (!wen_s || wd_fall) begin
            nodata_q <= 10'h000;
        end else if (nodata_q != 10'(NODATA_NXT)) begin
            nodata_q <= nodata_q + 10'h001;
        end
    end

    assign wf_set = wen_s & (~HEAD_LOAD_O | (nodata_q == 10'(NODATA_CYC)));

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wf_q <= 1'b0;
        end else if (wf_set) begin
            wf_q <= 1'b1;
        end else if (wfr_s) begin
            wf_q <= 1'b0;
        end
    end

    assign WR_FAULT_N_O = ~wf_q;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            idx_cnt_q <= 18'h00000;
        end else if (idx_rise) begin
            idx_cnt_q <= 18'(INDEX_CYC);
        end else if (idx_cnt_q != 18'h00000) begin
            idx_cnt_q <= idx_cnt_q - 18'h00001;
        end
    end

    // separated read pulses
    // Read pulses are suppressed while writing, when read circuitry is off.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdd_cnt_q <= 5'h00;
            rdc_cnt_q <= 5'h00;
        end else begin
            if (rdd_s && !rdd_prev_q && !wen_s) begin
                rdd_cnt_q <= 5'(PULSE_CYC);
            end else if (rdd_cnt_q != 5'h00) begin
                rdd_cnt_q <= rdd_cnt_q - 5'h01;
            end
            if (rdc_s && !rdc_prev_q && !wen_s) begin
                rdc_cnt_q <= 5'(PULSE_CYC);
            end else if (rdc_cnt_q != 5'h00) begin
                rdc_cnt_q <= rdc_cnt_q - 5'h01;
            end
        end
    end

    assign INDEX_N_O   = (idx_cnt_q == 18'h00000);
    assign RD_DATA_N_O = (rdd_cnt_q == 5'h00);
    assign RD_CLK_N_O  = (rdc_cnt_q == 5'h00);

    step_in_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        step_rise && dir_s && track_q < 7'(`FDI_TRACK_LAST) |=> track_q == $past(track_q) + 7'h01 && STEP_IN_O)
        else $error("inward step did not advance track");

    step_out_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        step_rise && !dir_s && track_q != 7'h00 |=> track_q == $past(track_q) - 7'h01 && STEP_OUT_O)
        else $error("outward step did not retreat track");

    track_zero_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        step_rise && !dir_s && track_q == 7'h01 |=> ##1 !TRACK0_N_O)
        else $error("track zero not reported after reaching track 00");

    ready_gate_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        !READY_N_O |-> $past(pwr_s) && $past(door_s) && $past(spd_s))
        else $error("ready asserted without power, door and speed");

    head_load_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        $fell(sel_s) |=> !HEAD_LOAD_O)
        else $error("head stayed loaded after deselect");

    protect_block_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        prot_s |-> !WR_GATE_O && !ERASE_O ##1 !PROTECT_N_O)
        else $error("write or erase active with protect hole");

    erase_follow_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        wen_s && !prot_s && !$past(prot_s) && $past(wen_s) |-> ERASE_O)
        else $error("erase current off during write");

    fault_set_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        wen_s && !HEAD_LOAD_O |=> !WR_FAULT_N_O)
        else $error("write without head load did not latch fault");

    fault_clear_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        wfr_s && !wf_set |=> WR_FAULT_N_O)
        else $error("fault reset did not clear fault");

    index_len_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        idx_rise |=> !INDEX_N_O [*8])
        else $error("index pulse too short");

    rd_pulse_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        rdd_s && !rdd_prev_q && !wen_s |=> !RD_DATA_N_O ##[PULSE_CYC:PULSE_CYC] RD_DATA_N_O || rdd_s)
        else $error("read data pulse width wrong");

endmodule

`default_nettype wire

// File: design/fdi_params.svh
// Constants for the flexible disk drive interface logic.
// Assumes a 100 MHz reference clock; counts derive from printed figures.
`ifndef FDI_PARAMS_SVH
`define FDI_PARAMS_SVH

`define FDI_CLK_MHZ        100
`define FDI_BIT_RATE_BPS   249984
`define FDI_PULSE_NS       250
`define FDI_PULSE_CYC      ((`FDI_PULSE_NS * `FDI_CLK_MHZ) / 1000)
`define FDI_INDEX_US       1500
`define FDI_INDEX_CYC      (`FDI_INDEX_US * `FDI_CLK_MHZ)
`define FDI_CELL_CYC       ((`FDI_CLK_MHZ * 1000000) / `FDI_BIT_RATE_BPS)
`define FDI_NODATA_CELLS   2
`define FDI_NODATA_CYC     (`FDI_NODATA_CELLS * `FDI_CELL_CYC)
`define FDI_TRACK_LAST     76
`define FDI_TRACK_RST      0

`endif

// File: design/fdi_pkg.sv
// Types shared by the drive interface logic.
// Assumes fdi_params.svh carries the numeric constants.
package fdi_pkg;

    typedef logic [6:0] fdi_track_t;

    typedef enum logic [1:0] {
        FDI_WS_IDLE  = 2'b00,
        FDI_WS_WRITE = 2'b01,
        FDI_WS_BLOCK = 2'b11
    } fdi_wr_state_t;

endpackage

// File: design/fdi_sync.sv
// Two-flop synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ps
`default_nettype none

module fdi_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule

`default_nettype wire

// File: dv/fdi_ctl_model.sv
// Behavioural diskette controller driving the drive interface lines.
// Assumes the drive samples every line asynchronously; delays in ns.
`timescale 1ns/1ps
`default_nettype none

module fdi_ctl_model #(
    parameter int STEP_GAP_NS = 2000
) (
    input  wire logic track0_n_i,
    output logic      step_n_o,
    output logic      dir_in_n_o,
    output logic      select_n_o,
    output logic      wr_en_n_o,
    output logic      wf_clear_n_o,
    output logic      wr_data_n_o,
    output logic      low_cur_n_o
);
    logic lclk;
    int   trk;

    // every line idles deasserted, high on the terminated wire
    initial begin
        {step_n_o, dir_in_n_o, select_n_o, wr_en_n_o} = 4'hF;
        {wf_clear_n_o, wr_data_n_o, low_cur_n_o} = 3'h7;
        trk = 0;
        lclk = 1'b0;
        #17;
        forever #62.5 lclk = ~lclk;
    end

    // one long pulse per track, direction settled around it
    // Gap is far below the 10 ms move time to keep runs short
    task automatic step(input logic inward);
        dir_in_n_o = ~inward;
        #1000;
        step_n_o = 1'b0;
        #10000;
        step_n_o = 1'b1;
        #1000;
        dir_in_n_o = 1'b1;
        trk = inward ? trk + 1 : (trk > 0 ? trk - 1 : 0);
        // reduced current on inner tracks, not gated by writing
        low_cur_n_o = ~(trk > 41);
        #(STEP_GAP_NS);
    endtask

    // step outward until the drive reports track zero
    task automatic recal();
        for (int i = 0; i < 80 && track0_n_i; i++) step(1'b0);
        trk = 0;
    endtask

    // a single unit select, held for the whole command
    task automatic select(input logic on);
        select_n_o = ~on;
        #500;
    endtask

    // each pulse two link periods, 250 ns
    task automatic pulse();
        wr_data_n_o = 1'b0;
        repeat (2) @(posedge lclk);
        wr_data_n_o = 1'b1;
    endtask

    // clock pulse opens each 4 us cell, data pulse mid-cell for ones
    task automatic write_byte(input logic [7:0] b);
        wr_en_n_o = 1'b0;
        @(posedge lclk);
        for (int i = 7; i >= 0; i--) begin
            pulse();
            repeat (14) @(posedge lclk);
            if (b[i]) pulse();
            else repeat (2) @(posedge lclk);
            repeat (14) @(posedge lclk);
        end
        wr_en_n_o = 1'b1;
    endtask

    // Write enable with no data, used by the fault tests and the protect test
    task automatic hold_enable(input int ns);
        wr_en_n_o = 1'b0;
        #(ns);
        wr_en_n_o = 1'b1;
    endtask

    task automatic clear_fault();
        wf_clear_n_o = 1'b0;
        #1000;
        wf_clear_n_o = 1'b1;
        #500;
    endtask

    task automatic set_low(input logic on);
        low_cur_n_o = ~on;
    endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the drive side of the disk interface.
// Assumes fdi_drive and the controller model; sensors driven at negedge.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("Error at %0t ns: got %0h expected %0h", $time, got, exp); end end

module tb_top;
    logic REF_CLK_I, RST_N_I, POWER_OK_I, DOOR_CLOSED_I, SPEED_OK_I, PROTECT_HOLE_I;
    logic INDEX_HOLE_I, RD_DATA_BIT_I, RD_CLK_BIT_I, HEAD_STRAP_I;
    wire logic step_n, dir_n, sel_n, wen_n, wfc_n, wdat_n, low_n;
    logic INDEX_N_O, TRACK0_N_O, PROTECT_N_O, WR_FAULT_N_O, READY_N_O, RD_DATA_N_O, RD_CLK_N_O;
    logic HEAD_LOAD_O, WR_GATE_O, ERASE_O, LOW_CUR_O, WR_BIT_O, STEP_IN_O, STEP_OUT_O;
    fdi_pkg::fdi_track_t TRACK_O;
    int num_errors, checked, n_in, n_out, n_bit, run[3], len[3];
    logic [2:0] low_v;

    fdi_drive #(.INDEX_CYC(50)) u_dut (
        .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .STEP_N_I(step_n), .DIR_IN_N_I(dir_n),
        .SELECT_N_I(sel_n), .WR_EN_N_I(wen_n), .WF_CLEAR_N_I(wfc_n), .WR_DATA_N_I(wdat_n),
        .LOW_CUR_N_I(low_n), .POWER_OK_I(POWER_OK_I), .DOOR_CLOSED_I(DOOR_CLOSED_I),
        .SPEED_OK_I(SPEED_OK_I), .PROTECT_HOLE_I(PROTECT_HOLE_I), .INDEX_HOLE_I(INDEX_HOLE_I),
        .RD_DATA_BIT_I(RD_DATA_BIT_I), .RD_CLK_BIT_I(RD_CLK_BIT_I), .HEAD_STRAP_I(HEAD_STRAP_I),
        .INDEX_N_O(INDEX_N_O), .TRACK0_N_O(TRACK0_N_O), .PROTECT_N_O(PROTECT_N_O),
        .WR_FAULT_N_O(WR_FAULT_N_O), .READY_N_O(READY_N_O), .RD_DATA_N_O(RD_DATA_N_O),
        .RD_CLK_N_O(RD_CLK_N_O), .HEAD_LOAD_O(HEAD_LOAD_O), .WR_GATE_O(WR_GATE_O),
        .ERASE_O(ERASE_O), .LOW_CUR_O(LOW_CUR_O), .WR_BIT_O(WR_BIT_O), .STEP_IN_O(STEP_IN_O),
        .STEP_OUT_O(STEP_OUT_O), .TRACK_O(TRACK_O));

    fdi_ctl_model u_ctl (
        .track0_n_i(TRACK0_N_O), .step_n_o(step_n), .dir_in_n_o(dir_n), .select_n_o(sel_n),
        .wr_en_n_o(wen_n), .wf_clear_n_o(wfc_n), .wr_data_n_o(wdat_n), .low_cur_n_o(low_n));

    always #5 REF_CLK_I = ~REF_CLK_I;

    // Event counts and the length of the last low run of each pulse output
    assign low_v = {INDEX_N_O, RD_DATA_N_O, RD_CLK_N_O};
    always @(posedge REF_CLK_I) begin
        n_in  <= n_in + int'(STEP_IN_O === 1'b1);
        n_out <= n_out + int'(STEP_OUT_O === 1'b1);
        n_bit <= n_bit + int'(WR_BIT_O === 1'b1);
        for (int i = 0; i < 3; i++) begin
            run[i] <= (low_v[2-i] === 1'b0) ? run[i] + 1 : 0;
            if (low_v[2-i] === 1'b0) len[i] <= run[i] + 1;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge REF_CLK_I);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Whole run takes roughly 150 us
    initial begin
        #800000;
        num_errors++;
        print_verdict();
    end

    initial begin
        REF_CLK_I = 1'b0;
        RST_N_I = 1'b0;
        {POWER_OK_I, DOOR_CLOSED_I, SPEED_OK_I, PROTECT_HOLE_I} = 4'h0;
        {INDEX_HOLE_I, RD_DATA_BIT_I, RD_CLK_BIT_I} = 3'h0;
        HEAD_STRAP_I = 1'b1;
        cyc(1);
        `CHK({INDEX_N_O, TRACK0_N_O, PROTECT_N_O, WR_FAULT_N_O, READY_N_O, RD_DATA_N_O}, 6'h3F)
        cyc(1);
        RST_N_I = 1'b1;
        cyc(5);
        `CHK(TRACK0_N_O, 1'b0)
        $display("Test reset finished");
        for (int v = 0; v < 8; v++) begin
            {POWER_OK_I, DOOR_CLOSED_I, SPEED_OK_I} = v[2:0];
            cyc(6);
            `CHK(READY_N_O, logic'(v != 7))
        end
        $display("Test ready finished");
        u_ctl.step(1'b0);
        `CHK({n_out, 25'h0, TRACK_O}, {32'd0, 25'h0, 7'h00})
        repeat (3) u_ctl.step(1'b1);
        `CHK({n_in, 25'h0, TRACK_O, TRACK0_N_O}, {32'd3, 25'h0, 7'h03, 1'b1})
        u_ctl.step(1'b0);
        `CHK(TRACK_O, 7'h02)
        u_ctl.recal();
        `CHK({n_out, 25'h0, TRACK_O, TRACK0_N_O}, {32'd3, 25'h0, 7'h00, 1'b0})
        $display("Test stepping finished");
        u_ctl.select(1'b1);
        cyc(6);
        `CHK(HEAD_LOAD_O, 1'b1)
        fork
            u_ctl.write_byte(8'hA5);
            begin
                cyc(100);
                `CHK({WR_GATE_O, ERASE_O}, 2'b11)
            end
        join
        cyc(6);
        `CHK(n_bit, 12)
        `CHK({WR_GATE_O, ERASE_O, WR_FAULT_N_O}, 3'b001)
        $display("Test write finished");
        fork
            u_ctl.hold_enable(12000);
            begin
                cyc(500);
                `CHK(WR_FAULT_N_O, 1'b1)
                cyc(600);
                `CHK(WR_FAULT_N_O, 1'b0)
            end
        join
        u_ctl.clear_fault();
        `CHK(WR_FAULT_N_O, 1'b1)
        u_ctl.select(1'b0);
        cyc(6);
        `CHK(HEAD_LOAD_O, 1'b0)
        // Without the strap a selected unit keeps its head unloaded
        HEAD_STRAP_I = 1'b0;
        u_ctl.select(1'b1);
        cyc(6);
        `CHK(HEAD_LOAD_O, 1'b0)
        u_ctl.select(1'b0);
        HEAD_STRAP_I = 1'b1;
        u_ctl.hold_enable(300);
        cyc(6);
        `CHK(WR_FAULT_N_O, 1'b0)
        u_ctl.clear_fault();
        `CHK(WR_FAULT_N_O, 1'b1)
        $display("Test fault finished");
        u_ctl.select(1'b1);
        PROTECT_HOLE_I = 1'b1;
        cyc(6);
        `CHK(PROTECT_N_O, 1'b0)
        fork
            u_ctl.hold_enable(2000);
            begin
                cyc(100);
                `CHK({WR_GATE_O, ERASE_O}, 2'b00)
            end
        join
        PROTECT_HOLE_I = 1'b0;
        u_ctl.set_low(1'b1);
        cyc(6);
        `CHK(LOW_CUR_O, 1'b1)
        u_ctl.set_low(1'b0);
        cyc(6);
        `CHK(LOW_CUR_O, 1'b0)
        $display("Test protect finished");
        for (int i = 0; i < 3; i++) begin
            cyc(2);
            {INDEX_HOLE_I, RD_DATA_BIT_I, RD_CLK_BIT_I} = 3'b100 >> i;
            cyc(3);
            {INDEX_HOLE_I, RD_DATA_BIT_I, RD_CLK_BIT_I} = 3'b000;
            cyc(80);
            `CHK(len[i], (i == 0) ? 50 : 25)
        end
        $display("Test pulses finished");
        print_verdict();
    end
endmodule
`default_nettype wire
